// *** src/dual_wiper_i2c_slave.sv ***
// Two-wire slave that sets the tap positions of two 128-step wipers
`timescale 1ns/1ns
module dual_wiper_i2c_slave (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic addr_select_bit2_i,
    input wire logic addr_select_bit1_i,
    input wire logic addr_select_bit0_i,
    output logic [6:0] wiper_position_reg_ch0_o,
    output logic [6:0] wiper_position_reg_ch1_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    ////////////////////////////////////////////////////////////////////////////////
    logic [4:0] pins_sync;
    logic scl_s, sda_s;
    logic [2:0] straps_s;

    // Clock line is only ever sampled, never driven
    pin_sync #(.WIDTH(5)) u_sync (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .d_i({scl_i, sda_i, addr_select_bit2_i, addr_select_bit1_i, addr_select_bit0_i}),
        .q_o(pins_sync)
    );

    assign scl_s = pins_sync[4];
    assign sda_s = pins_sync[3];
    assign straps_s = pins_sync[2:0];

    ////////////////////////////////////////////////////////////////////////////////
    // Edge and condition detection
    ////////////////////////////////////////////////////////////////////////////////
    logic scl_d_r, sda_d_r;
    logic scl_rise, scl_fall, start_cond, stop_cond;

    // Delayed copies of the synchronised lines
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else if (ce_i)
        begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    // Data moving while clock stays high marks start or stop
    assign start_cond = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_cond = scl_s & scl_d_r & ~sda_d_r & sda_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Protocol state
    ////////////////////////////////////////////////////////////////////////////////
    wiper_pkg::phase_t phase_r, phase_nxt;
    logic [3:0] bit_cnt_r, bit_cnt_nxt; // 0..7 data bits, 8 is the ack slot
    logic [7:0] shift_r, shift_nxt; // Incoming byte
    logic [7:0] reg_addr_r, reg_addr_nxt; // Selected register
    logic [7:0] tx_r, tx_nxt; // Outgoing byte during reads
    logic ack_r, ack_nxt; // Acknowledge pending for the ninth clock
    logic master_ack_r, master_ack_nxt; // Master acked last read byte
    logic [6:0] wiper0_r, wiper0_nxt, wiper1_r, wiper1_nxt;
    logic sda_low_r, sda_low_nxt; // Pull data line low
    logic [7:0] rx_byte;
    logic [7:0] next_rd; // Byte of the following read place

    assign rx_byte = {shift_r[6:0], sda_s};

    // Wiper value addressed by the register pointer
    function automatic logic [7:0] read_value(input logic [7:0] a, input logic [6:0] w0, input logic [6:0] w1);
        read_value = 8'h00;
        if (a == wiper_pkg::REG_ADDR_CH0)
        begin
            read_value = {1'b0, w0};
        end
        else if (a == wiper_pkg::REG_ADDR_CH1)
        begin
            read_value = {1'b0, w1};
        end
    endfunction
    assign next_rd = read_value(reg_addr_r + 8'h01, wiper0_r, wiper1_r);

    // Next-state logic for the whole byte engine
    always_comb
    begin
        phase_nxt = phase_r;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt = shift_r;
        reg_addr_nxt = reg_addr_r;
        tx_nxt = tx_r;
        ack_nxt = ack_r;
        master_ack_nxt = master_ack_r;
        wiper0_nxt = wiper0_r;
        wiper1_nxt = wiper1_r;
        sda_low_nxt = sda_low_r;
        if (start_cond || stop_cond)
        begin
            // Start restarts identification, stop returns to standby; no stale read ack survives
            phase_nxt = start_cond ? wiper_pkg::ST_ID : wiper_pkg::ST_IDLE;
            bit_cnt_nxt = 4'h0;
            ack_nxt = 1'b0;
            master_ack_nxt = 1'b0;
            sda_low_nxt = 1'b0;
        end
        else if (scl_rise && phase_r != wiper_pkg::ST_IDLE && phase_r != wiper_pkg::ST_IGNORE)
        begin
            if (bit_cnt_r <= wiper_pkg::BIT_LAST)
            begin
                shift_nxt = rx_byte;
                bit_cnt_nxt = bit_cnt_r + 4'h1;
                if (bit_cnt_r == wiper_pkg::BIT_LAST)
                begin
                    case (phase_r)
                        wiper_pkg::ST_ID:
                        begin
                            // Match fixed prefix and strap levels
                            if (rx_byte[7:4] == wiper_pkg::ID_PREFIX && rx_byte[3:1] == straps_s)
                            begin
                                ack_nxt = 1'b1;
                                tx_nxt = read_value(reg_addr_r, wiper0_r, wiper1_r);
                            end
                            else
                            begin
                                phase_nxt = wiper_pkg::ST_IGNORE;
                            end
                        end
                        wiper_pkg::ST_ADDR:
                        begin
                            reg_addr_nxt = rx_byte;
                            ack_nxt = 1'b1;
                        end
                        wiper_pkg::ST_DATA:
                        begin
                            ack_nxt = 1'b1;
                        end
                        default:
                        begin
                            ack_nxt = 1'b0;
                        end
                    endcase
                end
            end
            else
            begin
                // Ninth clock: commit written data and sample master ack
                bit_cnt_nxt = 4'h0;
                if (phase_r == wiper_pkg::ST_DATA)
                begin
                    if (reg_addr_r == wiper_pkg::REG_ADDR_CH0)
                    begin
                        wiper0_nxt = shift_r[6:0];
                    end
                    else if (reg_addr_r == wiper_pkg::REG_ADDR_CH1)
                    begin
                        wiper1_nxt = shift_r[6:0];
                    end
                    // Sequential write steps to the next channel
                    reg_addr_nxt = reg_addr_r + 8'h01;
                end
                else if (phase_r == wiper_pkg::ST_ID)
                begin
                    // Direction applies only once the identification ack slot is over
                    phase_nxt = shift_r[0] ? wiper_pkg::ST_READ : wiper_pkg::ST_ADDR;
                end
                else if (phase_r == wiper_pkg::ST_ADDR)
                begin
                    phase_nxt = wiper_pkg::ST_DATA;
                end
                else if (phase_r == wiper_pkg::ST_READ)
                begin
                    master_ack_nxt = ~sda_s;
                    if (sda_s)
                    begin
                        phase_nxt = wiper_pkg::ST_IGNORE; // Master nack ends the read
                    end
                end
            end
        end
        else if (scl_fall && phase_r != wiper_pkg::ST_IDLE && phase_r != wiper_pkg::ST_IGNORE)
        begin
            // Line changes only after a falling clock edge
            if (bit_cnt_r == 4'h8 && ack_r)
            begin
                sda_low_nxt = 1'b1;
                ack_nxt = 1'b0;
            end
            else if (phase_r == wiper_pkg::ST_READ && bit_cnt_r <= wiper_pkg::BIT_LAST)
            begin
                if (bit_cnt_r == 4'h0 && master_ack_r)
                begin
                    // Next byte after master ack
                    reg_addr_nxt = reg_addr_r + 8'h01;
                    tx_nxt = next_rd;
                    sda_low_nxt = ~next_rd[7];
                    master_ack_nxt = 1'b0;
                end
                else
                begin
                    sda_low_nxt = ~tx_r[3'h7 - bit_cnt_r[2:0]];
                end
            end
            else
            begin
                sda_low_nxt = 1'b0;
            end
        end
    end

    // Register all protocol state; wipers start at mid tap
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            phase_r <= wiper_pkg::ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            reg_addr_r <= 8'h00;
            tx_r <= 8'h00;
            ack_r <= 1'b0;
            master_ack_r <= 1'b0;
            wiper0_r <= wiper_pkg::WIPER_RESET[6:0];
            wiper1_r <= wiper_pkg::WIPER_RESET[6:0];
            sda_low_r <= 1'b0;
        end
        else if (ce_i)
        begin
            phase_r <= phase_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= shift_nxt;
            reg_addr_r <= reg_addr_nxt;
            tx_r <= tx_nxt;
            ack_r <= ack_nxt;
            master_ack_r <= master_ack_nxt;
            wiper0_r <= wiper0_nxt;
            wiper1_r <= wiper1_nxt;
            sda_low_r <= sda_low_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs: data value tied low, the rest straight from flip-flops
    ////////////////////////////////////////////////////////////////////////////////
    assign sda_o = 1'b0;
    assign sda_oe_o = sda_low_r;
    assign wiper_position_reg_ch0_o = wiper0_r;
    assign wiper_position_reg_ch1_o = wiper1_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    ////////////////////////////////////////////////////////////////////////////////
    AST_OE_ONLY_AFTER_FALL:
    assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $rose(sda_oe_o) |-> $past(scl_fall, 1) || $past(~ce_i, 1))
    else $error("data line driven without a falling clock");
    AST_NO_CHANGE_CLOCK_HIGH:
    assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (scl_s && scl_d_r && !start_cond && !stop_cond) |=> $stable(sda_oe_o))
    else $error("data line changed while clock high");
    AST_OPEN_DRAIN:
    assert property (@(posedge clk_sys_i) disable iff (reset_i) sda_o == 1'b0)
    else $error("data line driven high");
    AST_MISMATCH_SILENT:
    assert property (@(posedge clk_sys_i) disable iff (reset_i)
        phase_r == wiper_pkg::ST_IGNORE |-> !sda_oe_o)
    else $error("answered a foreign address");
    AST_ID_MATCH:
    assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (ce_i && scl_rise && phase_r == wiper_pkg::ST_ID && bit_cnt_r == 4'h8 && phase_nxt == wiper_pkg::ST_ADDR)
        |-> shift_r[3:1] == straps_s && shift_r[7:4] == wiper_pkg::ID_PREFIX && !shift_r[0])
    else $error("identification accepted with wrong address");
    AST_COMMIT_CH0:
    assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (ce_i && scl_rise && !start_cond && !stop_cond && phase_r == wiper_pkg::ST_DATA
         && bit_cnt_r == 4'h8 && reg_addr_r == wiper_pkg::REG_ADDR_CH0)
        |=> wiper0_r == $past(shift_r[6:0]))
    else $error("channel 0 write not committed");
    AST_COMMIT_CH1:
    assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (ce_i && scl_rise && !start_cond && !stop_cond && phase_r == wiper_pkg::ST_DATA
         && bit_cnt_r == 4'h8 && reg_addr_r == wiper_pkg::REG_ADDR_CH1)
        |=> wiper1_r == $past(shift_r[6:0]) && $stable(wiper0_r))
    else $error("channel 1 write not committed");
    AST_WIPER_ONLY_ON_COMMIT:
    assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !(phase_r == wiper_pkg::ST_DATA && bit_cnt_r == 4'h8) |=> $stable(wiper0_r) && $stable(wiper1_r))
    else $error("wiper changed outside commit");
endmodule

// *** src/pin_sync.sv ***
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    // First stage is read only by the second stage
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] q_nxt;

    initial
    begin
        if (WIDTH < 1)
        begin
            $error("pin_sync WIDTH must be positive");
        end
    end

    // Next values: shift one stage per enabled clock
    always_comb
    begin
        meta_nxt = ce_i ? d_i : meta_r;
        q_nxt = ce_i ? meta_r : q_o;
    end

    // Reset to all ones: both bus lines idle high under pull-up
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            meta_r <= '1;
            q_o <= '1;
        end
        else
        begin
            meta_r <= meta_nxt;
            q_o <= q_nxt;
        end
    end
endmodule

// *** src/wiper_pkg.sv ***
// Constants shared by the dual wiper two-wire slave
package wiper_pkg;
    localparam logic [3:0] ID_PREFIX = 4'ha;       // Fixed upper nibble of identification byte
    localparam logic [7:0] WIPER_RESET = 8'h40;    // Mid tap after reset
    localparam logic [7:0] REG_ADDR_CH0 = 8'h00;   // Channel 0 wiper register
    localparam logic [7:0] REG_ADDR_CH1 = 8'h01;   // Channel 1 wiper register
    localparam logic [6:0] TAP_MAX = 7'h7f;        // Tap nearest the high terminal
    localparam logic [3:0] BIT_LAST = 4'h7;        // Index of the eighth bit of a byte
    localparam int SYNC_STAGES = 2;                // Flip-flops before logic reads a pin

    // Transaction phases; Gray coded along the write path
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ID = 3'b001,
        ST_ADDR = 3'b011,
        ST_DATA = 3'b010,
        ST_READ = 3'b110,
        ST_IGNORE = 3'b111
    } phase_t;
endpackage

// *** tb/i2c_master_model.sv ***
// Behavioural bus master that clocks frames into the dual wiper slave
`timescale 1ns/1ns
module i2c_master_model (
    input wire logic clk_sys_i,
    input wire logic sda_i,
    output logic scl_oe_o,
    output logic sda_oe_o
);
    // Quarter of a 160 ns bus period, counted in system clocks
    localparam int QTR = 4;

    // Both lines released at time zero; the pull-ups hold them high
    initial
    begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Waits a number of system clocks; every pin change lands after an edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    // Start or repeated start: data falls while the clock is released high
    task automatic start();
        sda_oe_o <= 1'b0;
        tick(QTR);
        scl_oe_o <= 1'b0;
        tick(2 * QTR);
        sda_oe_o <= 1'b1;
        tick(2 * QTR);
        scl_oe_o <= 1'b1;
        tick(QTR);
    endtask

    // Nine clocks, MSB first; bit 0 is the acknowledge slot
    // Data moves only in the low phase, so it is stable across the rise
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--)
        begin
            sda_oe_o <= ~tx[i];
            tick(QTR);
            scl_oe_o <= 1'b0;
            tick(QTR);
            rx[i] = sda_i;
            tick(QTR);
            scl_oe_o <= 1'b1;
            tick(QTR);
        end
    endtask

    // Stop: data rises while the clock is high, then the bus rests idle
    task automatic stop();
        sda_oe_o <= 1'b1;
        tick(QTR);
        scl_oe_o <= 1'b0;
        tick(2 * QTR);
        sda_oe_o <= 1'b0;
        tick(4 * QTR);
    endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the dual wiper two-wire slave
`timescale 1ns/1ns
module tb;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1; // Held for the first 20 clocks
    logic ce_i = 1'b1; // Left running; freezing is not exercised here
    logic [2:0] strap = 3'h0; // Address select straps
    logic m_scl_oe, m_sda_oe, sda_o, sda_oe_o;
    logic [6:0] wp0, wp1;
    logic [6:0] exp_wp [0:1]; // Expected wiper taps
    logic [8:0] rx; // Last nine bits seen on the data line
    logic [31:0] seed = 32'h72d2;
    logic oe_q = 1'b0; // Data enable one clock back
    int miscompares = 0;
    int checks = 0;
    // Open-drain wires: whoever pulls wins, the pull-up gives the high
    wire scl_line = ~m_scl_oe;
    wire sda_line = ~m_sda_oe & (~sda_oe_o | sda_o);

    initial
    begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    dual_wiper_i2c_slave DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce_i), .scl_i(scl_line),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_select_bit2_i(strap[2]),
        .addr_select_bit1_i(strap[1]), .addr_select_bit0_i(strap[0]),
        .wiper_position_reg_ch0_o(wp0), .wiper_position_reg_ch1_o(wp1));

    i2c_master_model M (.clk_sys_i(clk_sys_i), .sda_i(sda_line), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));

    ////////////////////////////////////////////////////////////////////////
    // Repeatable pseudo-random source
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Byte a read should return; unmapped places read as zero
    function automatic logic [7:0] exp_rd(input int r);
        return (r < 2) ? {1'b0, exp_wp[r]} : 8'h00;
    endfunction

    // Byte-wide comparison
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Single-bit comparison (acknowledge slots, pin levels)
    task automatic chk_bit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask

    task automatic chk_wipers();
        chk_byte("wiper ch0", {1'b0, exp_wp[0]}, {1'b0, wp0});
        chk_byte("wiper ch1", {1'b0, exp_wp[1]}, {1'b0, wp1});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Write frame; a bad prefix or strap mismatch must get no acknowledge
    task automatic wr(input logic [2:0] a, input logic [3:0] pfx, input logic [7:0] ra,
        input logic [7:0] d0, input logic [7:0] d1, input int n);
        logic ok;
        logic [7:0] d;
        ok = (a === strap) && (pfx === 4'ha);
        M.start();
        M.xfer({pfx, a, 1'b0, 1'b1}, rx);
        chk_bit("id ack", ~ok, rx[0]);
        if (ok)
        begin
            M.xfer({ra, 1'b1}, rx);
            chk_bit("addr ack", 1'b0, rx[0]);
            for (int i = 0; i < n; i++)
            begin
                d = (i == 0) ? d0 : d1;
                M.xfer({d, 1'b1}, rx);
                chk_bit("data ack", 1'b0, rx[0]);
                if (int'(ra) + i < 2)
                    exp_wp[int'(ra) + i] = d[6:0];
                chk_wipers();
            end
        end
        M.stop();
        chk_wipers();
    endtask

    // Pointer set by a write, repeated start, two bytes read back
    task automatic rd(input logic [7:0] ra);
        M.start();
        M.xfer({4'ha, strap, 1'b0, 1'b1}, rx);
        M.xfer({ra, 1'b1}, rx);
        M.start();
        M.xfer({4'ha, strap, 1'b1, 1'b1}, rx);
        chk_bit("read id ack", 1'b0, rx[0]);
        M.xfer({8'hff, 1'b0}, rx);
        chk_byte("read byte", exp_rd(int'(ra)), rx[8:1]);
        M.xfer({8'hff, 1'b1}, rx);
        chk_byte("read next", exp_rd(int'(ra) + 1), rx[8:1]);
        M.stop();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // The device may move the data line only while the bus clock is low
    always @(posedge clk_sys_i)
    begin
        // Outputs are unknown before the first reset edge, so the check waits for release
        if (!reset_i && scl_line)
            chk_bit("data enable during high clock", oe_q, sda_oe_o);
        if (sda_oe_o)
            chk_bit("driven data value", 1'b0, sda_o);
        oe_q <= sda_oe_o;
    end

    // Verdict and the end of the run
    task automatic end_sim();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        repeat (100000) @(posedge clk_sys_i);
        miscompares++;
        $display("unexpected run length: expected below 100000 cycles, seen 100000");
        end_sim();
    end

    initial
    begin
        repeat (20) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        exp_wp[0] = 7'h40;
        exp_wp[1] = 7'h40;
        chk_wipers();
        // Hand-picked corners: range ends, bit 7 set, sequential, unmapped, refusals
        wr(strap, 4'ha, 8'h00, 8'h7f, 8'h00, 1);
        wr(strap, 4'ha, 8'h01, 8'h80, 8'h00, 1);
        rd(8'h00);
        wr(strap, 4'ha, 8'h00, 8'h15, 8'hff, 2);
        wr(strap, 4'ha, 8'h02, 8'h33, 8'h00, 1);
        wr(strap ^ 3'h1, 4'ha, 8'h00, 8'h01, 8'h00, 1);
        wr(strap, 4'h5, 8'h00, 8'h01, 8'h00, 1);
        rd(8'h01);
        // Random straps, registers and values
        for (int k = 0; k < 12; k++)
        begin
            seed = xorshift(seed);
            strap <= seed[2:0];
            repeat (8) @(posedge clk_sys_i);
            wr(seed[3] ? strap : ~strap, 4'ha, {7'h00, seed[4]}, seed[15:8], seed[23:16], seed[5] ? 2 : 1);
            rd({7'h00, seed[6]});
        end
        // Reset in mid-run brings both wipers back to mid tap
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        exp_wp[0] = 7'h40;
        exp_wp[1] = 7'h40;
        chk_wipers();
        wr(strap, 4'ha, 8'h01, 8'h2a, 8'h00, 1);
        end_sim();
    end
endmodule
